/* verilog/trim_regs_pkg.sv */
// Constants and carrier types for the sampling timing and offset trim bank.
package trim_regs_pkg;

  // --------------------------------------------------------------------------
  // Register bus geometry and register offsets
  // --------------------------------------------------------------------------
  localparam int          ADDR_W                = 12;
  localparam int          DATA_W                = 8;
  localparam logic [11:0] THIRD_FOR_FIRST_ADDR  = 12'h087;
  localparam logic [11:0] THIRD_FOR_SECOND_ADDR = 12'h088;
  localparam logic [11:0] SECOND_DUAL_ADDR      = 12'h089;
  localparam logic [11:0] INPUT_A_LO_ADDR       = 12'h08a;
  localparam logic [11:0] INPUT_A_HI_ADDR       = 12'h08b;
  localparam logic [11:0] INPUT_B_LO_ADDR       = 12'h08c;
  localparam logic [11:0] INPUT_B_HI_ADDR       = 12'h08d;
  localparam logic [11:0] CAL_STATUS_ADDR       = 12'h0f0;

  // --------------------------------------------------------------------------
  // Values after reset (factory trim defaults) and field layout
  // --------------------------------------------------------------------------
  localparam logic [7:0]  TIMING_TRIM_RST = 8'h80;
  localparam logic [15:0] OFFSET_TRIM_RST = 16'h0800;
  localparam int          OFFSET_W        = 12;
  localparam logic [15:0] OFFSET_FIELD    = 16'h0fff;
  localparam int          ST_FG_RUNNING   = 0;
  localparam int          ST_FOREGROUND_CALIBRATION_DONE      = 1;
  localparam int          ST_OS_EN        = 2;
  localparam int          ST_BG_EN        = 3;
  localparam int          ST_BGOS_EN      = 4;
  localparam int          ST_HALTED       = 5;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic foreground_calibration_running;
    logic foreground_calibration_done;
    logic offset_calibration_enable;
    logic background_calibration_enable;
    logic background_offset_calibration_enable;
    logic calibration_halted_flag;
  } cal_status_s;

  typedef struct packed {
    logic        valid;
    logic        to_input_b;
    logic [11:0] value;
  } cal_offset_load_s;

  typedef enum logic [2:0] {
    ROLE_NONE   = 3'b001,
    ROLE_FIRST  = 3'b010,
    ROLE_SECOND = 3'b100
  } third_role_e;

endpackage

/* verilog/sample_timing_offset_trim_regs.sv */
// Timing and offset trim register bank for the converter cores.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module sample_timing_offset_trim_regs
(
  input  wire logic                            clock,         // 125 MHz
  input  wire logic                            rst_n,         // Async reset
  input  wire trim_regs_pkg::reg_req_s         req,           // Bus request
  output logic [7:0]                           rd_data,       // Read data
  input  wire trim_regs_pkg::cal_status_s      cal,           // Cal state
  input  wire trim_regs_pkg::cal_offset_load_s cal_load,      // Cal update
  input  wire logic                            dual_mode,     // Dual-channel
  input  wire trim_regs_pkg::third_role_e      third_role,    // Third core use
  input  wire logic                            first_on_b,    // Core on input b
  output logic [7:0]                           second_timing, // Applied trim
  output logic [7:0]                           third_timing,  // Applied trim
  output logic                                 third_active,  // Third in use
  output logic [11:0]                          first_offset   // Unsigned trim
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  third_for_first;
    logic [7:0]  third_for_second;
    logic [7:0]  second_dual;
    logic [15:0] input_a;
    logic [15:0] input_b;
    logic [7:0]  rdata;
    logic [7:0]  second_timing;
    logic [7:0]  third_timing;
    logic        third_active;
    logic [11:0] first_offset;
  } state_s;

  localparam state_s STATE_RST = '{
    third_for_first:  trim_regs_pkg::TIMING_TRIM_RST,
    third_for_second: trim_regs_pkg::TIMING_TRIM_RST,
    second_dual:      trim_regs_pkg::TIMING_TRIM_RST,
    input_a:          trim_regs_pkg::OFFSET_TRIM_RST,
    input_b:          trim_regs_pkg::OFFSET_TRIM_RST,
    rdata:            8'h00,
    second_timing:    trim_regs_pkg::TIMING_TRIM_RST,
    third_timing:     trim_regs_pkg::TIMING_TRIM_RST,
    third_active:     1'b0,
    first_offset:     trim_regs_pkg::OFFSET_TRIM_RST[11:0]
  };

  state_s state_q;
  state_s state_d;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Replaces one byte of a sixteen-bit trim word.
  function automatic logic [15:0] merge_byte
  (
    input logic [15:0] old_word,
    input logic        high,
    input logic [7:0]  new_byte
  );
    logic [15:0] word;
    word = old_word;
    if (high)
    begin
      word[15:8] = new_byte;
    end
    else
    begin
      word[7:0] = new_byte;
    end
    return word;
  endfunction

  // Loads a calibration result into the field, keeping the upper bits.
  function automatic logic [15:0] load_field
  (
    input logic [15:0] old_word,
    input logic [11:0] value
  );
    return (old_word & ~trim_regs_pkg::OFFSET_FIELD) | {4'h0, value};
  endfunction

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] status;
    status = 8'h00;
    state_d = state_q;

    // Host writes; every trim is read/write at its own byte address.
    if (req.wr)
    begin
      unique case (req.addr)
        trim_regs_pkg::THIRD_FOR_FIRST_ADDR:
        begin
          state_d.third_for_first = req.wdata;
        end
        trim_regs_pkg::THIRD_FOR_SECOND_ADDR:
        begin
          state_d.third_for_second = req.wdata;
        end
        trim_regs_pkg::SECOND_DUAL_ADDR:
        begin
          state_d.second_dual = req.wdata;
        end
        trim_regs_pkg::INPUT_A_LO_ADDR, trim_regs_pkg::INPUT_A_HI_ADDR:
        begin
          state_d.input_a = merge_byte(state_q.input_a, req.addr[0],
                                       req.wdata);
        end
        trim_regs_pkg::INPUT_B_LO_ADDR, trim_regs_pkg::INPUT_B_HI_ADDR:
        begin
          state_d.input_b = merge_byte(state_q.input_b, req.addr[0],
                                       req.wdata);
        end
        default:
        begin
          state_d.input_b = state_q.input_b;
        end
      endcase
    end

    // Background offset calibration updates the field; in a cycle with a host
    // write to the same trim it wins, and the host byte is lost.
    if (cal_load.valid)
    begin
      if (cal_load.to_input_b)
      begin
        state_d.input_b = load_field(state_q.input_b,
                                     cal_load.value);
      end
      else
      begin
        state_d.input_a = load_field(state_q.input_a,
                                     cal_load.value);
      end
    end

    status[trim_regs_pkg::ST_FG_RUNNING] = cal.foreground_calibration_running;
    status[trim_regs_pkg::ST_FOREGROUND_CALIBRATION_DONE]    = cal.foreground_calibration_done;
    status[trim_regs_pkg::ST_OS_EN]      = cal.offset_calibration_enable;
    status[trim_regs_pkg::ST_BG_EN]      = cal.background_calibration_enable;
    status[trim_regs_pkg::ST_BGOS_EN]    =
      cal.background_offset_calibration_enable;
    status[trim_regs_pkg::ST_HALTED]     = cal.calibration_halted_flag;

    // Read data stand for exactly the cycle after the read strobe.
    state_d.rdata = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        trim_regs_pkg::THIRD_FOR_FIRST_ADDR:
        begin
          state_d.rdata = state_q.third_for_first;
        end
        trim_regs_pkg::THIRD_FOR_SECOND_ADDR:
        begin
          state_d.rdata = state_q.third_for_second;
        end
        trim_regs_pkg::SECOND_DUAL_ADDR:
        begin
          state_d.rdata = state_q.second_dual;
        end
        trim_regs_pkg::INPUT_A_LO_ADDR:
        begin
          state_d.rdata = state_q.input_a[7:0];
        end
        trim_regs_pkg::INPUT_A_HI_ADDR:
        begin
          state_d.rdata = state_q.input_a[15:8];
        end
        trim_regs_pkg::INPUT_B_LO_ADDR:
        begin
          state_d.rdata = state_q.input_b[7:0];
        end
        trim_regs_pkg::INPUT_B_HI_ADDR:
        begin
          state_d.rdata = state_q.input_b[15:8];
        end
        trim_regs_pkg::CAL_STATUS_ADDR:
        begin
          state_d.rdata = status;
        end
        default:
        begin
          state_d.rdata = 8'h00;
        end
      endcase
    end

    // Applied timing trims; outside dual-channel mode the third core is
    // handled by the single-channel trims and is idle here.
    state_d.second_timing = state_q.second_dual;
    state_d.third_active  = 1'b0;
    state_d.third_timing  = state_q.third_timing;
    if (dual_mode)
    begin
      unique case (third_role)
        trim_regs_pkg::ROLE_FIRST:
        begin
          state_d.third_timing = state_q.third_for_first;
          state_d.third_active = 1'b1;
        end
        trim_regs_pkg::ROLE_SECOND:
        begin
          state_d.third_timing = state_q.third_for_second;
          state_d.third_active = 1'b1;
        end
        trim_regs_pkg::ROLE_NONE:
        begin
          state_d.third_active = 1'b0;
        end
        default:
        begin
          state_d.third_active = 1'b0;
        end
      endcase
    end

    // Offset applied as a plain unsigned magnitude.
    state_d.first_offset = first_on_b ?
      state_q.input_b[trim_regs_pkg::OFFSET_W-1:0] :
      state_q.input_a[trim_regs_pkg::OFFSET_W-1:0];
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rd_data       = state_q.rdata;
  assign second_timing = state_q.second_timing;
  assign third_timing  = state_q.third_timing;
  assign third_active  = state_q.third_active;
  assign first_offset  = state_q.first_offset;

endmodule

/* dv/trim_regs_sva.sv */
// Port assertions for the sampling timing and offset trim bank.
`timescale 1ns/1ps
module trim_regs_sva
(
  input wire logic                            clock,         // Clock
  input wire logic                            rst_n,         // Reset
  input wire trim_regs_pkg::reg_req_s         req,           // Bus request
  input wire logic [7:0]                      rd_data,       // Read data
  input wire trim_regs_pkg::cal_offset_load_s cal_load,      // Cal update
  input wire logic                            dual_mode,     // Dual mode
  input wire trim_regs_pkg::third_role_e      third_role,    // Third role
  input wire logic                            first_on_b,    // Input b
  input wire logic [7:0]                      second_timing, // Applied trim
  input wire logic [7:0]                      third_timing,  // Applied trim
  input wire logic                            third_active,  // Third in use
  input wire logic [11:0]                     first_offset   // Offset
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic act;
  logic r_ff;
  logic r_ss;
  assign r_ff = third_role == trim_regs_pkg::ROLE_FIRST;
  assign r_ss = third_role == trim_regs_pkg::ROLE_SECOND;
  assign act = dual_mode && (r_ff || r_ss);
  property p_idle_zero;
    !req.rd |=> rd_data == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not cleared");
  property p_readback;
    req.wr ##1 req.rd && req.addr == $past(req.addr) && !cal_load.valid
      && req.addr >= 12'h087 && req.addr <= 12'h089
      |=> rd_data == $past(req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("timing trim read back wrong");
  property p_second;
    req.wr && req.addr == 12'h089 |=> ##1 second_timing == $past(req.wdata, 2);
  endproperty
  a_second: assert property (p_second)
    else $error("second core trim not applied");
  property p_third_first;
    (req.wr && req.addr == 12'h087 && dual_mode && r_ff) ##1 (dual_mode && r_ff)
      |=> third_timing == $past(req.wdata, 2);
  endproperty
  a_third_first: assert property (p_third_first)
    else $error("third core trim for first not applied");
  property p_third_second;
    (req.wr && req.addr == 12'h088 && dual_mode && r_ss) ##1 (dual_mode && r_ss)
      |=> third_timing == $past(req.wdata, 2);
  endproperty
  a_third_second: assert property (p_third_second)
    else $error("third core trim for second not applied");
  property p_active;
    1'b1 |=> third_active == $past(act);
  endproperty
  a_active: assert property (p_active)
    else $error("third core activity wrong");
  property p_hold;
    !act |=> $stable(third_timing);
  endproperty
  a_hold: assert property (p_hold)
    else $error("third core trim changed while idle");
  property p_offset_a;
    cal_load.valid && !cal_load.to_input_b ##1 !first_on_b
      |=> first_offset == $past(cal_load.value, 2);
  endproperty
  a_offset_a: assert property (p_offset_a)
    else $error("input a offset not applied");
  property p_offset_b;
    cal_load.valid && cal_load.to_input_b ##1 first_on_b
      |=> first_offset == $past(cal_load.value, 2);
  endproperty
  a_offset_b: assert property (p_offset_b)
    else $error("input b offset not applied");
endmodule

bind sample_timing_offset_trim_regs trim_regs_sva i_trim_regs_sva
(
  .clock(clock), .rst_n(rst_n), .req(req), .rd_data(rd_data),
  .cal_load(cal_load), .dual_mode(dual_mode), .third_role(third_role),
  .first_on_b(first_on_b), .second_timing(second_timing),
  .third_timing(third_timing), .third_active(third_active),
  .first_offset(first_offset)
);

/* dv/tb_sample_timing_offset_trim_regs.sv */
// Self-checking bench for the sampling timing and offset trim bank.
`timescale 1ns/1ps
module tb_sample_timing_offset_trim_regs;
  logic                            clock;
  logic                            rst_n;
  trim_regs_pkg::reg_req_s         req;
  logic [7:0]                      rd_data;
  trim_regs_pkg::cal_status_s      cal;
  trim_regs_pkg::cal_offset_load_s cal_load;
  logic                            dual_mode;
  trim_regs_pkg::third_role_e      third_role;
  logic                            first_on_b;
  logic [7:0]                      second_timing;
  logic [7:0]                      third_timing;
  logic                            third_active;
  logic [11:0]                     first_offset;
  logic [7:0]                      sh [0:6];
  logic [7:0]                      rd_exp;
  logic [7:0]                      exp_q;
  logic [7:0]                      exp_third;
  logic [7:0]                      d;
  trim_regs_pkg::cal_status_s      c_val;
  logic                            rd_q;
  logic                            act;
  integer                          seed;
  integer                          n_errors;
  integer                          checks;
  integer                          cycles;
  integer                          i;
  integer                          k;

  sample_timing_offset_trim_regs i_sample_timing_offset_trim_regs
  (
    .clock(clock), .rst_n(rst_n), .req(req), .rd_data(rd_data), .cal(cal),
    .cal_load(cal_load), .dual_mode(dual_mode), .third_role(third_role),
    .first_on_b(first_on_b), .second_timing(second_timing),
    .third_timing(third_timing), .third_active(third_active),
    .first_offset(first_offset)
  );

  // --------------------------------------------------------------------------
  // Tasks and checking
  // --------------------------------------------------------------------------
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks = checks + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A read carries its expected byte in v; a write carries its data.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
    req.wr <= w;
    req.rd <= ~w;
    req.addr <= a;
    req.wdata <= v;
    rd_exp <= v;
    @(posedge clock);
  endtask

  task automatic idle;
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [11:0] off_exp(input logic b);
    off_exp = b ? {sh[6][3:0], sh[5]} : {sh[4][3:0], sh[3]};
  endfunction

  function automatic logic [7:0] stat_exp(input trim_regs_pkg::cal_status_s s);
    stat_exp = 8'h00;
    stat_exp[trim_regs_pkg::ST_FG_RUNNING] = s.foreground_calibration_running;
    stat_exp[trim_regs_pkg::ST_FOREGROUND_CALIBRATION_DONE] = s.foreground_calibration_done;
    stat_exp[trim_regs_pkg::ST_OS_EN] = s.offset_calibration_enable;
    stat_exp[trim_regs_pkg::ST_BG_EN] = s.background_calibration_enable;
    stat_exp[trim_regs_pkg::ST_BGOS_EN] =
      s.background_offset_calibration_enable;
    stat_exp[trim_regs_pkg::ST_HALTED] = s.calibration_halted_flag;
  endfunction

  // Model of the factory trims that every reset restores.
  task automatic load_defaults;
    exp_third = trim_regs_pkg::TIMING_TRIM_RST;
    for (i = 0; i < 7; i++)
      sh[i] = (i < 3) ? trim_regs_pkg::TIMING_TRIM_RST :
        (i % 2) ? trim_regs_pkg::OFFSET_TRIM_RST[7:0] :
        trim_regs_pkg::OFFSET_TRIM_RST[15:8];
  endtask

  task automatic outs;
    idle;
    idle;
    @(negedge clock);
    act = dual_mode && third_role inside {3'b010, 3'b100};
    if (act)
      exp_third = third_role[1] ? sh[0] : sh[1];
    cmp("third_active", {11'h000, act}, {11'h000, third_active});
    cmp("third_timing", {4'h0, exp_third},
        {4'h0, third_timing});
    cmp("second_timing", {4'h0, sh[2]},
        {4'h0, second_timing});
    cmp("first_offset", off_exp(first_on_b),
        first_offset);
    @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    rd_q <= req.rd;
    exp_q <= rd_exp;
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end

  always @(negedge clock)
    if (rd_q === 1'b1)
      cmp("rd_data", {4'h0, exp_q}, {4'h0, rd_data});

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    seed = 84654;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    req = '0;
    cal = '0;
    cal_load = '0;
    dual_mode = 1'b0;
    third_role = trim_regs_pkg::ROLE_NONE;
    first_on_b = 1'b0;
    rd_exp = 8'h00;
    load_defaults;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    outs;
    for (i = 0; i < 7; i++)
      bus(1'b0, 12'h087 + 12'(i), sh[i]);
    bus(1'b0, 12'h0a0, 8'h00);
    for (i = 0; i < 24; i++)
    begin
      k = {$random(seed)} % 7;
      d = 8'($random(seed));
      sh[k] = d;
      bus(1'b1, 12'h087 + 12'(k), d);
      bus(1'b0, 12'h087 + 12'(k), d);
    end
    for (i = 0; i < 8; i++)
    begin
      dual_mode <= i[0];
      third_role <= trim_regs_pkg::third_role_e'(3'(1 << (i / 2)));
      first_on_b <= i[1];
      for (k = 0; k < 3; k++)
      begin
        sh[k] = 8'($random(seed));
        bus(1'b1, 12'h087 + 12'(k), sh[k]);
      end
      outs;
    end
    for (i = 0; i < 2; i++)
    begin
      d = i[0] ? 8'h00 : 8'hff;
      cal_load <= '{1'b1, i[0], {d[3:0], d}};
      first_on_b <= i[0];
      sh[3 + 2 * i] = d;
      sh[4 + 2 * i][3:0] = d[3:0];
      idle;
      cal_load <= '0;
      outs;
      bus(1'b0, 12'h08a + 12'(2 * i), sh[3 + 2 * i]);
      bus(1'b0, 12'h08b + 12'(2 * i), sh[4 + 2 * i]);
    end
    outs;
    // Calibration state moves only while no offset trim is touched.
    for (i = 0; i < 8; i++)
    begin
      c_val = 6'($random(seed));
      d = 8'($random(seed));
      cal <= c_val;
      bus(1'b1, trim_regs_pkg::CAL_STATUS_ADDR, d);
      bus(1'b0, trim_regs_pkg::CAL_STATUS_ADDR, stat_exp(c_val));
    end
    cal <= '0;
    idle;
    rst_n <= 1'b0;
    idle;
    rst_n <= 1'b1;
    load_defaults;
    outs;
    for (i = 0; i < 7; i++)
      bus(1'b0, 12'h087 + 12'(i), sh[i]);
    idle;
    tally_and_finish;
  end
endmodule
